// *** pdov_asserts.sv ***
// Port-level assertions for the port D override block
`timescale 1ns/1ps
`default_nettype none
`include "pdov_regs.vh"
module pdov_asserts (
  // Clock, reset and bus
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Port D pins and controls
  input wire logic [7:0] i_portd_pin,
  input wire logic [7:0] o_portd_oe,
  input wire logic [7:0] o_portd_pullup,
  input wire logic [7:0] o_pin_change_src,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Completed writes to the two control words
  wire wr = i_psel & i_penable & o_pready & i_pwrite;
  wire ctl = wr && i_paddr[11:2] == `PDOV_IDX_PERIPH_CTRL;
  wire mcu = wr && i_paddr[11:2] == `PDOV_IDX_MCU_CTRL;
  // Edges since reset; sync stages hold reset zeros before four
  logic [2:0] up;
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      up <= 3'h0;
    else if (!up[2])
      up <= up + 3'h1;
  a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready not one cycle after access");
  a_err_reads_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
    else $error("refused access not clean");
  a_rdata_clean: assert property (o_prdata[31:8] == 24'h00_0000 && (o_pready || o_prdata == 0))
    else $error("read data outside answer");
  a_pud_all_off: assert property (mcu && i_pwdata[4] |=> ##1 o_portd_pullup == 8'h00)
    else $error("pull-up left on");
  a_tx1_drives: assert property (ctl && i_pwdata[2] |=> ##1 o_portd_oe[3] && !o_portd_pullup[3])
    else $error("pin 3 not forced out");
  a_tx0_drives: assert property (ctl && i_pwdata[0] |=> ##1 o_portd_oe[1] && !o_portd_pullup[1])
    else $error("pin 1 not forced out");
  a_rx1_input: assert property (ctl && i_pwdata[3] |=> ##1 !o_portd_oe[2])
    else $error("pin 2 not forced in");
  a_rx0_input: assert property (ctl && i_pwdata[1] |=> ##1 !o_portd_oe[0])
    else $error("pin 0 not forced in");
  a_change_lag: assert property (up[2] |-> o_pin_change_src == $past(i_portd_pin, 3))
    else $error("pin change source lag");
  c_tx1_on: cover property (ctl && i_pwdata[2]);
  c_refused: cover property (o_pslverr);
  c_irq: cover property (o_irq);
endmodule
bind pdov_top pdov_asserts u_chk (.*);
`default_nettype wire

// *** pdov_board.sv ***
// Board model: pin level from port drive, board driver, pull-up or float
`timescale 1ns/1ps
`default_nettype none
module pdov_board (
  // Clock for the float pattern
  input wire logic i_clock,
  // Port side
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_pullup,
  // Board driver
  input wire logic [7:0] i_den,
  input wire logic [7:0] i_dv,
  // Resolved levels
  output wire logic [7:0] o_pin
);
  // Open pins toggle so a stale level never reads as valid
  logic [7:0] flt = 8'h00;
  always @(posedge i_clock)
    flt <= ~flt;
  // Port drive beats board, board beats pull-up
  assign o_pin = (i_oe & i_out) | (~i_oe & i_den & i_dv) | (~i_oe & ~i_den & (i_pullup | flt));
endmodule
`default_nettype wire

// *** pdov_pin.v ***
// Per-pin override mux: pull-up, direction, value and input enable
`timescale 1ns/1ps
`default_nettype none
module pdov_pin (
  // Port register bits
  input wire i_dir,
  input wire i_out,
  input wire i_pud,
  // Override controls
  input wire i_pullup_override_en,
  input wire i_pullup_override_val,
  input wire i_direction_override_en,
  input wire i_direction_override_val,
  input wire i_pin_value_override_en,
  input wire i_pin_value_override_val,
  input wire i_input_enable_override_en,
  input wire i_input_enable_override_val,
  input wire i_sleep,
  // Pin controls
  output wire o_pullup,
  output wire o_oe,
  output wire o_val,
  output wire o_die
);
  // Effective direction
  assign o_oe = i_direction_override_en ? i_direction_override_val : i_dir;
  // Pull-up: only for input with data one, gated by global disable
  assign o_pullup = i_pullup_override_en ? i_pullup_override_val : (~i_dir & i_out & ~i_pud);
  // Driven value
  assign o_val = i_pin_value_override_en ? i_pin_value_override_val : i_out;
  // Digital input enable; sleep gating overridden by alternate functions
  assign o_die = i_input_enable_override_en ? i_input_enable_override_val : ~i_sleep;
endmodule
`default_nettype wire

// *** pdov_regs.vh ***
// Register offsets, field positions and reset values of the port override block
`ifndef PDOV_REGS_VH
`define PDOV_REGS_VH
// Printed register indices; byte address is four times the index
`define PDOV_IDX_PORT_A_OUTPUT_VALUE_IN 8'h00
`define PDOV_IDX_PORT_A_OUTPUT_VALUE_DIR 8'h01
`define PDOV_IDX_PORT_A_OUTPUT_VALUE_OUT 8'h02
`define PDOV_IDX_PORT_B_OUTPUT_VALUE_DIR 8'h04
`define PDOV_IDX_PORT_B_OUTPUT_VALUE_OUT 8'h05
`define PDOV_IDX_MCU_CTRL 8'h35
// Own registers for port D and the loose control bits
`define PDOV_IDX_PORTD_IN 8'h40
`define PDOV_IDX_PORTD_DIR 8'h41
`define PDOV_IDX_PORTD_OUT 8'h42
`define PDOV_IDX_PERIPH_CTRL 8'h43
`define PDOV_IDX_PCMASK 8'h44
`define PDOV_IDX_IRQ_STATUS 8'h45
`define PDOV_IDX_IRQ_MASK 8'h46
// Control register fields
`define PDOV_MCU_PUD_BIT 4
`define PDOV_MCU_WMASK 8'hF3
// Peripheral control fields
`define PDOV_PC_TX0 0
`define PDOV_PC_RX0 1
`define PDOV_PC_TX1 2
`define PDOV_PC_RX1 3
`define PDOV_PC_SYNC1 4
`define PDOV_PC_GRP3 5
`define PDOV_PC_EXT_IRQ_0_IN 6
`define PDOV_PC_EXT_IRQ_1_IN 7
// Reset value of writable registers
`define PDOV_RST_BYTE 8'h00
`endif

// *** pdov_sync.v ***
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module pdov_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Data
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  // First stage, read only by the second
  reg [WIDTH-1:0] meta;
  // Two flops before any logic sees a pin
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// *** pdov_top.v ***
// Port D alternate-function override with APB registers for ports A, B, D
//
// What this block does
// - Compare B out on pin 4 needs dir one
// - Pin 4 serial clock: dir one out, zero in
// - Serial clock active only in synchronous mode
// - Serial1 transmit forces pin 3 output, data
// - Serial1 receive forces pin 2 input
// - Forced input keeps pull-up from data bit
// - Serial0 transmit forces pin 1 output, data
// - Serial0 receive forces pin 0 input
// - Pins 7..4: compare value override, input force
// - Pins 3..0: tx, rx, interrupt overrides
// - Pin 0 feeds timer3 count input
// - Pins 0..4 are pin-change sources 24..28
// - Pins 3,2 feed external interrupts 1,0
// - Global pull-up disable kills all pull-ups
`timescale 1ns/1ps
`default_nettype none
`include "pdov_regs.vh"
module pdov_top (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // Port pins as out, oe and pullup each; port D adds input enable
  input wire [7:0] i_port_a_output_value_pin,
  output reg [7:0] o_port_a_output_value_out,
  output reg [7:0] o_port_a_output_value_oe,
  output reg [7:0] o_port_a_output_value_pullup,
  output reg [7:0] o_port_b_output_value_out,
  output reg [7:0] o_port_b_output_value_oe,
  output reg [7:0] o_port_b_output_value_pullup,
  input wire [7:0] i_portd_pin,
  output reg [7:0] o_portd_out,
  output reg [7:0] o_portd_oe,
  output reg [7:0] o_portd_pullup,
  output reg [7:0] o_portd_die,
  // Peripheral side signals
  input wire i_sleep,
  input wire i_timer1_compare_a_out,
  input wire i_timer1_compare_b_out,
  input wire i_timer2_compare_a_out,
  input wire i_timer2_compare_b_out,
  input wire [3:0] i_compare_enable,
  input wire i_serial0_transmit_pin,
  input wire i_serial1_transmit_pin,
  input wire i_serial1_ext_clock,
  output reg o_serial0_receive_pin,
  output reg o_serial1_receive_pin,
  output reg o_serial1_ext_clock,
  output reg o_timer1_capture_in,
  output reg o_timer3_count_in,
  output reg o_ext_irq_0_in,
  output reg o_ext_irq_1_in,
  output reg [7:0] o_pin_change_src,
  // Interrupt
  output reg o_irq
);
  // Register storage
  reg [7:0] port_a_output_value_dir;
  reg [7:0] port_a_output_value_out;
  reg [7:0] port_b_output_value_dir;
  reg [7:0] port_b_output_value_out;
  reg [7:0] portd_dir;
  reg [7:0] portd_out;
  reg [7:0] mcu_ctrl;
  reg [7:0] periph_ctrl;
  reg [7:0] pc_mask;
  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  // Synchronised pin levels
  wire [7:0] port_a_output_value_sync;
  wire [7:0] portd_sync;
  reg [7:0] portd_prev;
  // Override vectors for port D
  reg [7:0] pullup_override_en;
  reg [7:0] pullup_override_val;
  reg [7:0] direction_override_en;
  reg [7:0] direction_override_val;
  reg [7:0] pin_value_override_en;
  reg [7:0] pin_value_override_val;
  reg [7:0] input_enable_override_en;
  wire [7:0] d_pull;
  wire [7:0] d_oe;
  wire [7:0] d_val;
  wire [7:0] d_die;
  // Bus decode
  wire [9:0] idx;
  wire wr_en;
  wire rd_en;
  wire global_pullup_disable;
  wire tx0;
  wire rx0;
  wire tx1;
  wire rx1;
  wire sync1;
  wire grp3;
  reg [7:0] rd_byte;
  reg hit;
  wire [7:0] events;

  assign idx = i_paddr[11:2];
  assign wr_en = i_psel & i_penable & i_pwrite & ~o_pready;
  assign rd_en = i_psel & i_penable & ~i_pwrite & ~o_pready;
  assign global_pullup_disable = mcu_ctrl[`PDOV_MCU_PUD_BIT];
  assign tx0 = periph_ctrl[`PDOV_PC_TX0];
  assign rx0 = periph_ctrl[`PDOV_PC_RX0];
  assign tx1 = periph_ctrl[`PDOV_PC_TX1];
  assign rx1 = periph_ctrl[`PDOV_PC_RX1];
  assign sync1 = periph_ctrl[`PDOV_PC_SYNC1];
  assign grp3 = periph_ctrl[`PDOV_PC_GRP3];

  // Pin inputs cross two flops before use
  pdov_sync #(.WIDTH(8)) u_sync_a (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_port_a_output_value_pin),
    .o_sync(port_a_output_value_sync)
  );
  pdov_sync #(.WIDTH(8)) u_sync_d (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_portd_pin),
    .o_sync(portd_sync)
  );

  // Override table for port D
  always @*
  begin
    pullup_override_en = 8'h00;
    pullup_override_val = 8'h00;
    direction_override_en = 8'h00;
    direction_override_val = 8'h00;
    // Compare outputs take the value only; direction stays with software
    pin_value_override_en = {i_compare_enable, 4'h0};
    pin_value_override_val = {i_timer2_compare_a_out, i_timer2_compare_b_out,
      i_timer1_compare_a_out, i_timer1_compare_b_out, 4'h0};
    // Serial clock out replaces compare value when synchronous and driven
    if (sync1 && portd_dir[4])
    begin
      pin_value_override_en[4] = 1'b1;
      pin_value_override_val[4] = i_serial1_ext_clock;
    end
    input_enable_override_en = pc_mask & {8{grp3}};
    input_enable_override_en[3] = input_enable_override_en[3] | periph_ctrl[`PDOV_PC_EXT_IRQ_1_IN];
    input_enable_override_en[2] = input_enable_override_en[2] | periph_ctrl[`PDOV_PC_EXT_IRQ_0_IN];
    // Pin 3: serial1 transmit
    pullup_override_en[3] = tx1;
    direction_override_en[3] = tx1;
    direction_override_val[3] = 1'b1;
    pin_value_override_en[3] = tx1;
    pin_value_override_val[3] = i_serial1_transmit_pin;
    // Pin 2: serial1 receive, pull-up follows data bit
    pullup_override_en[2] = rx1;
    pullup_override_val[2] = portd_out[2] & ~global_pullup_disable;
    direction_override_en[2] = rx1;
    // Pin 1: serial0 transmit
    pullup_override_en[1] = tx0;
    direction_override_en[1] = tx0;
    direction_override_val[1] = 1'b1;
    pin_value_override_en[1] = tx0;
    pin_value_override_val[1] = i_serial0_transmit_pin;
    // Pin 0: serial0 receive
    pullup_override_en[0] = rx0;
    pullup_override_val[0] = portd_out[0] & ~global_pullup_disable;
    direction_override_en[0] = rx0;
  end

  // One mux per pin
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_pin
      pdov_pin u_pin (
        .i_dir(portd_dir[g]),
        .i_out(portd_out[g]),
        .i_pud(global_pullup_disable),
        .i_pullup_override_en(pullup_override_en[g]),
        .i_pullup_override_val(pullup_override_val[g]),
        .i_direction_override_en(direction_override_en[g]),
        .i_direction_override_val(direction_override_val[g]),
        .i_pin_value_override_en(pin_value_override_en[g]),
        .i_pin_value_override_val(pin_value_override_val[g]),
        .i_input_enable_override_en(input_enable_override_en[g]),
        .i_input_enable_override_val(1'b1),
        .i_sleep(i_sleep),
        .o_pullup(d_pull[g]),
        .o_oe(d_oe[g]),
        .o_val(d_val[g]),
        .o_die(d_die[g])
      );
    end
  endgenerate

  // Read mux; unmapped addresses answer with an error
  always @*
  begin
    rd_byte = 8'h00;
    hit = 1'b1;
    case (idx[7:0])
      `PDOV_IDX_PORT_A_OUTPUT_VALUE_IN: rd_byte = port_a_output_value_sync;
      `PDOV_IDX_PORT_A_OUTPUT_VALUE_DIR: rd_byte = port_a_output_value_dir;
      `PDOV_IDX_PORT_A_OUTPUT_VALUE_OUT: rd_byte = port_a_output_value_out;
      `PDOV_IDX_PORT_B_OUTPUT_VALUE_DIR: rd_byte = port_b_output_value_dir;
      `PDOV_IDX_PORT_B_OUTPUT_VALUE_OUT: rd_byte = port_b_output_value_out;
      `PDOV_IDX_MCU_CTRL: rd_byte = mcu_ctrl;
      `PDOV_IDX_PORTD_IN: rd_byte = portd_sync;
      `PDOV_IDX_PORTD_DIR: rd_byte = portd_dir;
      `PDOV_IDX_PORTD_OUT: rd_byte = portd_out;
      `PDOV_IDX_PERIPH_CTRL: rd_byte = periph_ctrl;
      `PDOV_IDX_PCMASK: rd_byte = pc_mask;
      `PDOV_IDX_IRQ_STATUS: rd_byte = irq_status;
      `PDOV_IDX_IRQ_MASK: rd_byte = irq_mask;
      default: hit = 1'b0;
    endcase
    if (idx[9:8] != 2'b00)
    begin
      hit = 1'b0;
    end
  end

  // Pin-change events on enabled pins
  assign events = (portd_sync ^ portd_prev) & pc_mask & {8{grp3}};

  // Bus registers and sticky status; set wins over clear
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      port_a_output_value_dir <= `PDOV_RST_BYTE;
      port_a_output_value_out <= `PDOV_RST_BYTE;
      port_b_output_value_dir <= `PDOV_RST_BYTE;
      port_b_output_value_out <= `PDOV_RST_BYTE;
      portd_dir <= `PDOV_RST_BYTE;
      portd_out <= `PDOV_RST_BYTE;
      mcu_ctrl <= `PDOV_RST_BYTE;
      periph_ctrl <= `PDOV_RST_BYTE;
      pc_mask <= `PDOV_RST_BYTE;
      irq_status <= `PDOV_RST_BYTE;
      irq_mask <= `PDOV_RST_BYTE;
      portd_prev <= 8'h00;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      portd_prev <= portd_sync;
      // One wait state: ready the cycle after access begins
      o_pready <= i_psel & i_penable & ~o_pready;
      o_pslverr <= (wr_en | rd_en) & ~hit;
      o_prdata <= rd_en ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      irq_status <= irq_status | events;
      if (wr_en)
      begin
        case (idx[7:0])
          `PDOV_IDX_PORT_A_OUTPUT_VALUE_DIR: port_a_output_value_dir <= i_pwdata[7:0];
          `PDOV_IDX_PORT_A_OUTPUT_VALUE_OUT: port_a_output_value_out <= i_pwdata[7:0];
          `PDOV_IDX_PORT_B_OUTPUT_VALUE_DIR: port_b_output_value_dir <= i_pwdata[7:0];
          `PDOV_IDX_PORT_B_OUTPUT_VALUE_OUT: port_b_output_value_out <= i_pwdata[7:0];
          `PDOV_IDX_MCU_CTRL: mcu_ctrl <= i_pwdata[7:0] & `PDOV_MCU_WMASK;
          `PDOV_IDX_PORTD_DIR: portd_dir <= i_pwdata[7:0];
          `PDOV_IDX_PORTD_OUT: portd_out <= i_pwdata[7:0];
          `PDOV_IDX_PERIPH_CTRL: periph_ctrl <= i_pwdata[7:0];
          `PDOV_IDX_PCMASK: pc_mask <= i_pwdata[7:0];
          `PDOV_IDX_IRQ_STATUS: irq_status <= (irq_status & ~i_pwdata[7:0]) | events;
          `PDOV_IDX_IRQ_MASK: irq_mask <= i_pwdata[7:0];
          default: irq_mask <= irq_mask;
        endcase
      end
    end
  end

  // Registered pin controls and peripheral inputs
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_port_a_output_value_out <= 8'h00;
      o_port_a_output_value_oe <= 8'h00;
      o_port_a_output_value_pullup <= 8'h00;
      o_port_b_output_value_out <= 8'h00;
      o_port_b_output_value_oe <= 8'h00;
      o_port_b_output_value_pullup <= 8'h00;
      o_portd_out <= 8'h00;
      o_portd_oe <= 8'h00;
      o_portd_pullup <= 8'h00;
      o_portd_die <= 8'h00;
      o_serial0_receive_pin <= 1'b1;
      o_serial1_receive_pin <= 1'b1;
      o_serial1_ext_clock <= 1'b0;
      o_timer1_capture_in <= 1'b0;
      o_timer3_count_in <= 1'b0;
      o_ext_irq_0_in <= 1'b0;
      o_ext_irq_1_in <= 1'b0;
      o_pin_change_src <= 8'h00;
      o_irq <= 1'b0;
    end
    else
    begin
      // Plain ports A and B
      o_port_a_output_value_out <= port_a_output_value_out;
      o_port_a_output_value_oe <= port_a_output_value_dir;
      o_port_a_output_value_pullup <= ~port_a_output_value_dir & port_a_output_value_out & {8{~global_pullup_disable}};
      o_port_b_output_value_out <= port_b_output_value_out;
      o_port_b_output_value_oe <= port_b_output_value_dir;
      o_port_b_output_value_pullup <= ~port_b_output_value_dir & port_b_output_value_out & {8{~global_pullup_disable}};
      // Port D after overrides
      o_portd_out <= d_val;
      o_portd_oe <= d_oe;
      o_portd_pullup <= d_pull;
      o_portd_die <= d_die;
      // Pin levels handed to peripherals; receivers idle high when off
      o_serial0_receive_pin <= rx0 ? portd_sync[0] : 1'b1;
      o_serial1_receive_pin <= rx1 ? portd_sync[2] : 1'b1;
      // Clock input only in synchronous mode with pin as input
      o_serial1_ext_clock <= sync1 & ~portd_dir[4] & portd_sync[4];
      o_timer1_capture_in <= portd_sync[6];
      o_timer3_count_in <= portd_sync[0];
      o_ext_irq_0_in <= portd_sync[2];
      o_ext_irq_1_in <= portd_sync[3];
      // Bits 0..4 are sources 24..28, bits 5..7 carry 29..31
      o_pin_change_src <= portd_sync;
      o_irq <= |(irq_status & irq_mask);
    end
  end
endmodule
`default_nettype wire

// *** tb_pdov_top.sv ***
// Random and corner-case bench for the port D override block
`timescale 1ns/1ps
`default_nettype none
`include "pdov_regs.vh"
module tb_port_d_alternate_function_override;
  // Design inputs
  logic i_clock = 1'h0, i_rst_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_sleep = 1'h0, i_timer1_compare_a_out = 1'h0, i_timer1_compare_b_out = 1'h0;
  logic i_timer2_compare_a_out = 1'h0, i_timer2_compare_b_out = 1'h0, i_serial1_ext_clock = 1'h0;
  logic i_serial0_transmit_pin = 1'h0, i_serial1_transmit_pin = 1'h0;
  logic [3:0] i_compare_enable = 4'h0;
  wire [7:0] i_port_a_output_value_pin, i_portd_pin;
  // Design outputs
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_irq, o_serial0_receive_pin, o_serial1_receive_pin;
  wire o_serial1_ext_clock, o_timer1_capture_in, o_timer3_count_in, o_ext_irq_0_in, o_ext_irq_1_in;
  wire [7:0] o_port_a_output_value_out, o_port_a_output_value_oe, o_port_a_output_value_pullup, o_port_b_output_value_out, o_port_b_output_value_oe, o_port_b_output_value_pullup;
  wire [7:0] o_portd_out, o_portd_oe, o_portd_pullup, o_portd_die, o_pin_change_src;
  // Board drivers, read result, counters
  logic [7:0] a_den = 8'h00, a_dv = 8'h00, d_den = 8'h00, d_dv = 8'h00, rq;
  logic re;
  int mismatches = 0, checks_done = 0, cyc = 0;
  logic [31:0] seed = 32'h6d2a_e2a4;
  // Shadow of writable registers, in write order
  logic [7:0] st [9] = '{default: 8'h00};
  logic [7:0] wi [9] = '{`PDOV_IDX_PORTD_DIR, `PDOV_IDX_PORTD_OUT, `PDOV_IDX_PERIPH_CTRL,
    `PDOV_IDX_PCMASK, `PDOV_IDX_MCU_CTRL, `PDOV_IDX_PORT_A_OUTPUT_VALUE_DIR, `PDOV_IDX_PORT_A_OUTPUT_VALUE_OUT,
    `PDOV_IDX_PORT_B_OUTPUT_VALUE_DIR, `PDOV_IDX_PORT_B_OUTPUT_VALUE_OUT};
  wire [7:0] dir = st[0], dout = st[1], c = st[2], pcm = st[3];
  wire global_pullup_disable = st[4][`PDOV_MCU_PUD_BIT];
  pdov_top uut (.*);
  pdov_board u_pa (.i_clock, .i_oe(o_port_a_output_value_oe), .i_out(o_port_a_output_value_out), .i_pullup(o_port_a_output_value_pullup),
    .i_den(a_den), .i_dv(a_dv), .o_pin(i_port_a_output_value_pin));
  pdov_board u_pd (.i_clock, .i_oe(o_portd_oe), .i_out(o_portd_out), .i_pullup(o_portd_pullup),
    .i_den(d_den), .i_dv(d_dv), .o_pin(i_portd_pin));
  always #25 i_clock = ~i_clock;
  // Hang guard
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      complete_run;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Plain pull-up request, gated by the global disable
  function automatic logic [7:0] pu_x(input logic [7:0] d, input logic [7:0] o);
    return ~d & o & {8{~global_pullup_disable}};
  endfunction
  // Pin as {known mask, level}; open pins are unknown
  function automatic logic [15:0] pin_x(input logic [7:0] oe, v, pu, den, dv);
    return {oe | den | pu, (oe & v) | (~oe & den & dv) | (~oe & ~den & pu)};
  endfunction
  // Port D after overrides as {input en, pull-up, value, drive}
  function automatic logic [31:0] exp_d();
    logic [7:0] tm, rm, oe, pu, v, fi;
    tm = {4'h0, c[2], 1'h0, c[0], 1'h0};
    rm = {5'h00, c[3], 1'h0, c[1]};
    oe = (dir | tm) & ~rm;
    pu = (pu_x(dir, dout) & ~tm & ~rm) | (rm & dout & {8{~global_pullup_disable}});
    v = dout;
    v[1] = c[0] ? i_serial0_transmit_pin : v[1];
    v[3] = c[2] ? i_serial1_transmit_pin : v[3];
    v[4] = c[4] & dir[4] ? i_serial1_ext_clock : i_compare_enable[0] ? i_timer1_compare_b_out : v[4];
    v[5] = i_compare_enable[1] ? i_timer1_compare_a_out : v[5];
    v[6] = i_compare_enable[2] ? i_timer2_compare_b_out : v[6];
    v[7] = i_compare_enable[3] ? i_timer2_compare_a_out : v[7];
    fi = (pcm & {8{c[5]}}) | {4'h0, c[7], c[6], 2'h0} | {8{~i_sleep}};
    return {fi, pu, v, oe};
  endfunction
  task automatic cmp(input string nm, input logic [7:0] x, input logic [7:0] y);
    checks_done++;
    if (x !== y)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, x, y);
    end
  endtask
  // One transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= {2'h0, ix, 2'h0};
    i_pwdata <= {24'h00_0000, d};
    @(posedge i_clock);
    i_penable <= 1'h1;
    do
      @(posedge i_clock);
    while (o_pready !== 1'h1);
    rq = o_prdata[7:0];
    re = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clock);
  endtask
  // Readback of every shadowed register; control bits 3:2 read zero
  task automatic check_regs;
    for (int i = 0; i < 9; i++)
    begin
      apb(1'h0, wi[i], 8'h00);
      cmp($sformatf("reg %h", wi[i]), i == 4 ? st[i] & 8'hF3 : st[i], rq);
    end
  endtask
  // Random inputs and registers; a nonzero k fixes the peripheral control
  task automatic pass(input logic [7:0] k);
    logic [31:0] ex;
    logic [15:0] kp;
    seed = xs(seed);
    {i_compare_enable, i_sleep, i_timer1_compare_a_out, i_timer1_compare_b_out,
      i_timer2_compare_a_out, i_timer2_compare_b_out, i_serial0_transmit_pin,
      i_serial1_transmit_pin, i_serial1_ext_clock} <= seed[11:0];
    d_den <= seed[19:12] | 8'h5D;
    d_dv <= seed[27:20];
    a_den <= seed[31:24];
    a_dv <= seed[23:16];
    for (int i = 0; i < 9; i++)
    begin
      seed = xs(seed);
      st[i] = (i == 2 && k != 8'h00) ? k : i == 4 ? seed[7:0] & 8'h1C : seed[7:0];
      apb(1'h1, wi[i], st[i]);
    end
    repeat (6) @(posedge i_clock);
    ex = exp_d();
    kp = pin_x(ex[7:0], ex[15:8], ex[23:16], d_den, d_dv);
    cmp("d oe", ex[7:0], o_portd_oe);
    cmp("d pullup", ex[23:16], o_portd_pullup);
    cmp("d value", ex[15:8] & ex[7:0], o_portd_out & ex[7:0]);
    cmp("d input en", ex[31:24], o_portd_die);
    cmp("periph", {1'h0, (c[1] ? kp[0] : 1'h1), (c[3] ? kp[2] : 1'h1),
      c[4] & ~dir[4] & kp[4], kp[6], kp[0], kp[2], kp[3]}, {1'h0, o_serial0_receive_pin,
      o_serial1_receive_pin, o_serial1_ext_clock, o_timer1_capture_in, o_timer3_count_in,
      o_ext_irq_0_in, o_ext_irq_1_in});
    cmp("change src", kp[7:0] & kp[15:8], o_pin_change_src & kp[15:8]);
    apb(1'h0, `PDOV_IDX_PORTD_IN, 8'h00);
    cmp("d in reg", kp[7:0] & kp[15:8], rq & kp[15:8]);
    kp = pin_x(st[5], st[6], pu_x(st[5], st[6]), a_den, a_dv);
    cmp("a oe", st[5], o_port_a_output_value_oe);
    cmp("a value", st[6] & st[5], o_port_a_output_value_out & st[5]);
    cmp("a pullup", pu_x(st[5], st[6]), o_port_a_output_value_pullup);
    apb(1'h0, `PDOV_IDX_PORT_A_OUTPUT_VALUE_IN, 8'h00);
    cmp("a in reg", kp[7:0] & kp[15:8], rq & kp[15:8]);
    cmp("b oe", st[7], o_port_b_output_value_oe);
    cmp("b value", st[8] & st[7], o_port_b_output_value_out & st[7]);
    cmp("b pullup", pu_x(st[7], st[8]), o_port_b_output_value_pullup);
    check_regs;
  endtask
  // Pin-change event: raise, mask, clear
  task automatic irq_test;
    apb(1'h1, `PDOV_IDX_PORTD_DIR, 8'h00);
    apb(1'h1, `PDOV_IDX_PERIPH_CTRL, 8'h20);
    apb(1'h1, `PDOV_IDX_PCMASK, 8'h01);
    repeat (6) @(posedge i_clock);
    apb(1'h1, `PDOV_IDX_IRQ_STATUS, 8'hFF);
    apb(1'h1, `PDOV_IDX_IRQ_MASK, 8'h01);
    cmp("irq idle", 8'h00, {7'h00, o_irq});
    d_dv[0] <= ~d_dv[0];
    repeat (8) @(posedge i_clock);
    cmp("irq set", 8'h01, {7'h00, o_irq});
    apb(1'h0, `PDOV_IDX_IRQ_STATUS, 8'h00);
    cmp("status set", 8'h01, rq);
    apb(1'h1, `PDOV_IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge i_clock);
    cmp("irq masked", 8'h00, {7'h00, o_irq});
    apb(1'h1, `PDOV_IDX_IRQ_STATUS, 8'h01);
    apb(1'h0, `PDOV_IDX_IRQ_STATUS, 8'h00);
    cmp("status clear", 8'h00, rq);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'h1;
    @(posedge i_clock);
    check_regs;
    apb(1'h0, `PDOV_IDX_IRQ_MASK, 8'h00);
    cmp("mask reset", 8'h00, rq);
    apb(1'h1, 8'h03, 8'hFF);
    cmp("unmapped err", 8'h01, {7'h00, re});
    apb(1'h0, 8'h03, 8'h00);
    cmp("unmapped rd", 8'h00, rq);
    pass(8'hFF);
    pass(8'h10);
    repeat (40) pass(8'h00);
    irq_test;
    complete_run;
  end
endmodule
`default_nettype wire
